/* lsa_agen.sv */
`timescale 1ns/1ps
module lsa_agen (
  input  wire lsa_pkg::lsa_op_t op,       // Access kind
  input  wire logic [63:0]      base_val, // Base register value
  input  wire logic [15:0]      offset,   // Signed offset field
  output logic      [63:0]      addr,     // Effective address
  output logic                  misal     // Size and low bits not permitted
);

  assign addr = base_val + {{48{offset[15]}}, offset};

  // Partial and byte accesses are legal at any byte
  always_comb begin
    case (op)
      lsa_pkg::OP_LOAD_HALF_SIGNED, lsa_pkg::OP_LOAD_HALF_ZERO_EXT,
      lsa_pkg::OP_STORE_HALF: misal = addr[0];
      lsa_pkg::OP_LOAD_WORD_SIGNED, lsa_pkg::OP_LOAD_WORD_ZERO_EXT,
      lsa_pkg::OP_STORE_WORD: misal = |addr[1:0];
      lsa_pkg::OP_LOAD_DWORD, lsa_pkg::OP_STORE_DWORD: misal = |addr[2:0];
      default: misal = 1'b0;
    endcase
  end

endmodule : lsa_agen

/* lsa_exec.sv */
`timescale 1ns/1ps
module lsa_exec (
  input  wire logic              clk,        // Core clock
  input  wire logic              reset_n,    // Synchronous reset
  input  wire logic              mode64,     // 64-bit mode enables doubleword ops
  input  wire logic              req_valid,  // Request offered
  output logic                   req_ready,  // Idle and able to take a request
  input  wire lsa_pkg::lsa_req_t req,        // Decoded instruction and operands
  output logic                   mem_valid,  // Memory request pending
  output lsa_pkg::lsa_mem_t      mem,        // Memory request fields
  input  wire logic              mem_gnt,    // Memory accepts the request
  input  wire logic              mem_rvalid, // Load data returned
  input  wire logic [63:0]       mem_rdata,  // Aligned doubleword read
  output logic                   wb_valid,   // Destination write, one pulse
  output lsa_pkg::lsa_wb_t       wb,         // Destination number and value
  output logic                   exc_valid,  // Exception, one pulse
  output lsa_pkg::lsa_exc_t      exc         // Exception cause
);

  typedef enum logic [1:0] {ST_IDLE, ST_MEM_REQ, ST_LOAD_WAIT} lsa_state_t;

  lsa_state_t       state_reg;
  lsa_state_t       state_next;
  lsa_pkg::lsa_op_t op_reg;
  logic [2:0]       boff_reg;
  logic [63:0]      tgt_val_reg;
  logic [4:0]       tgt_reg_reg;

  logic [63:0] addr_c;
  logic        misal_c;
  logic [63:0] alu_res_c;
  logic        alu_ovf_c;
  logic        accept;
  logic        ldst_c;
  logic        ri_c;
  logic        ae_c;
  logic        trap_c;
  logic        fault_c;
  logic [7:0]  st_be_c;
  logic [63:0] st_wdata_c;
  logic [63:0] ld_res_c;

  lsa_agen u_agen (
    .op       (req.op),
    .base_val (req.src_val),
    .offset   (req.imm),
    .addr     (addr_c),
    .misal    (misal_c)
  );

  lsa_imm_alu u_alu (
    .op      (req.op),
    .src_val (req.src_val),
    .imm     (req.imm),
    .result  (alu_res_c),
    .ovf     (alu_ovf_c)
  );

  assign req_ready = state_reg == ST_IDLE;
  assign accept    = req_valid && req_ready;
  assign ldst_c    = lsa_pkg::is_load(req.op) || lsa_pkg::is_store(req.op);
  // Doubleword work is refused outside 64-bit mode
  assign ri_c      = lsa_pkg::needs_64(req.op) && !mode64;
  assign ae_c      = ldst_c && misal_c;
  assign trap_c    = (req.op == lsa_pkg::OP_ADD_IMM_TRAPPING) && alu_ovf_c;
  assign fault_c   = ri_c || ae_c || trap_c;
  assign mem_valid = state_reg == ST_MEM_REQ;

  // Store lanes: lane n of the doubleword holds address offset n
  always_comb begin
    logic [1:0]  wb2;
    logic [31:0] wtmp;
    logic [3:0]  bw;
    wb2        = addr_c[1:0];
    wtmp       = 32'h0;
    bw         = 4'h0;
    st_be_c    = lsa_pkg::BE_NONE;
    st_wdata_c = 64'h0;
    case (req.op)
      lsa_pkg::OP_STORE_BYTE: begin
        st_wdata_c = {8{req.tgt_val[7:0]}};
        st_be_c    = lsa_pkg::BE_BYTE << addr_c[2:0];
      end
      lsa_pkg::OP_STORE_HALF: begin
        st_wdata_c = {4{req.tgt_val[15:0]}};
        st_be_c    = lsa_pkg::BE_HALF << addr_c[2:0];
      end
      lsa_pkg::OP_STORE_WORD: begin
        st_wdata_c = {2{req.tgt_val[31:0]}};
        st_be_c    = lsa_pkg::BE_WORD << addr_c[2:0];
      end
      lsa_pkg::OP_STORE_WORD_LEFT_PART: begin
        wtmp       = req.tgt_val[31:0] >> {~wb2, 3'b000};
        bw         = lsa_pkg::BE_WLANE >> ~wb2;
        st_wdata_c = {2{wtmp}};
        st_be_c    = addr_c[2] ? {bw, 4'h0} : {4'h0, bw};
      end
      lsa_pkg::OP_STORE_WORD_RIGHT_PART: begin
        wtmp       = req.tgt_val[31:0] << {wb2, 3'b000};
        bw         = lsa_pkg::BE_WLANE << wb2;
        st_wdata_c = {2{wtmp}};
        st_be_c    = addr_c[2] ? {bw, 4'h0} : {4'h0, bw};
      end
      lsa_pkg::OP_STORE_DWORD: begin
        st_wdata_c = req.tgt_val;
        st_be_c    = lsa_pkg::BE_ALL;
      end
      lsa_pkg::OP_STORE_DWORD_LEFT_PART: begin
        st_wdata_c = req.tgt_val >> {~addr_c[2:0], 3'b000};
        st_be_c    = lsa_pkg::BE_ALL >> ~addr_c[2:0];
      end
      lsa_pkg::OP_STORE_DWORD_RIGHT_PART: begin
        st_wdata_c = req.tgt_val << {addr_c[2:0], 3'b000};
        st_be_c    = lsa_pkg::BE_ALL << addr_c[2:0];
      end
      default: begin
        st_wdata_c = 64'h0;
        st_be_c    = lsa_pkg::BE_NONE;
      end
    endcase
  end

  // Loads always read the whole doubleword and pick lanes here
  always_comb begin
    logic [63:0] sh_r;
    logic [31:0] word;
    logic [31:0] wmask;
    logic [31:0] wtmp;
    logic [63:0] dmask;
    logic [1:0]  wb2;
    sh_r  = mem_rdata >> {boff_reg, 3'b000};
    word  = boff_reg[2] ? mem_rdata[63:32] : mem_rdata[31:0];
    wb2   = boff_reg[1:0];
    wmask = lsa_pkg::ONES32;
    wtmp  = 32'h0;
    dmask = lsa_pkg::ONES64;
    case (op_reg)
      lsa_pkg::OP_LOAD_BYTE_SIGNED:   ld_res_c = {{56{sh_r[7]}}, sh_r[7:0]};
      lsa_pkg::OP_LOAD_BYTE_ZERO_EXT: ld_res_c = {56'h0, sh_r[7:0]};
      lsa_pkg::OP_LOAD_HALF_SIGNED:   ld_res_c = {{48{sh_r[15]}}, sh_r[15:0]};
      lsa_pkg::OP_LOAD_HALF_ZERO_EXT: ld_res_c = {48'h0, sh_r[15:0]};
      lsa_pkg::OP_LOAD_WORD_SIGNED:   ld_res_c = {{32{sh_r[31]}}, sh_r[31:0]};
      lsa_pkg::OP_LOAD_WORD_ZERO_EXT: ld_res_c = {32'h0, sh_r[31:0]};
      lsa_pkg::OP_LOAD_DWORD:         ld_res_c = sh_r;
      lsa_pkg::OP_LOAD_WORD_LEFT_PART: begin
        wmask    = lsa_pkg::ONES32 << {~wb2, 3'b000};
        wtmp     = ((word << {~wb2, 3'b000}) & wmask) | (tgt_val_reg[31:0] & ~wmask);
        ld_res_c = {{32{wtmp[31]}}, wtmp};
      end
      lsa_pkg::OP_LOAD_WORD_RIGHT_PART: begin
        wmask    = lsa_pkg::ONES32 >> {wb2, 3'b000};
        wtmp     = ((word >> {wb2, 3'b000}) & wmask) | (tgt_val_reg[31:0] & ~wmask);
        ld_res_c = {{32{wtmp[31]}}, wtmp};
      end
      lsa_pkg::OP_LOAD_DWORD_LEFT_PART: begin
        dmask    = lsa_pkg::ONES64 << {~boff_reg, 3'b000};
        ld_res_c = ((mem_rdata << {~boff_reg, 3'b000}) & dmask)
                   | (tgt_val_reg & ~dmask);
      end
      lsa_pkg::OP_LOAD_DWORD_RIGHT_PART: begin
        dmask    = lsa_pkg::ONES64 >> {boff_reg, 3'b000};
        ld_res_c = ((mem_rdata >> {boff_reg, 3'b000}) & dmask)
                   | (tgt_val_reg & ~dmask);
      end
      default: ld_res_c = 64'h0;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (accept && !fault_c && ldst_c) begin
          state_next = ST_MEM_REQ;
        end
      ST_MEM_REQ:
        if (mem_gnt) begin
          state_next = mem.we ? ST_IDLE : ST_LOAD_WAIT;
        end
      ST_LOAD_WAIT:
        if (mem_rvalid) begin
          state_next = ST_IDLE;
        end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Context for the load merge, held until data returns
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      op_reg      <= lsa_pkg::OP_LOAD_BYTE_SIGNED;
      boff_reg    <= 3'h0;
      tgt_val_reg <= 64'h0;
      tgt_reg_reg <= 5'h0;
    end else if (accept) begin
      op_reg      <= req.op;
      boff_reg    <= addr_c[2:0];
      tgt_val_reg <= req.tgt_val;
      tgt_reg_reg <= req.tgt_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mem <= '0;
    end else if (accept && ldst_c && !fault_c) begin
      mem.addr  <= addr_c;
      mem.we    <= lsa_pkg::is_store(req.op);
      mem.be    <= lsa_pkg::is_store(req.op) ? st_be_c : lsa_pkg::BE_ALL;
      mem.wdata <= st_wdata_c;
    end
  end

  // Immediate results retire the cycle after acceptance
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wb_valid <= 1'b0;
      wb       <= '0;
    end else if (accept && !ldst_c && !fault_c) begin
      wb_valid   <= 1'b1;
      wb.tgt_reg <= req.tgt_reg;
      wb.data    <= alu_res_c;
    end else if (state_reg == ST_LOAD_WAIT && mem_rvalid) begin
      wb_valid   <= 1'b1;
      wb.tgt_reg <= tgt_reg_reg;
      wb.data    <= ld_res_c;
    end else begin
      wb_valid <= 1'b0;
    end
  end

  // A faulting request leaves memory and the register file untouched
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      exc_valid <= 1'b0;
      exc       <= '0;
    end else begin
      exc_valid    <= accept && fault_c;
      exc.addr_err <= accept && ae_c;
      exc.overflow <= accept && trap_c;
      exc.reserved <= accept && ri_c;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_ok_accept(lsa_pkg::lsa_op_t o);
    accept && req.op == o && !fault_c;
  endsequence

  sequence s_load_back(lsa_pkg::lsa_op_t o);
    state_reg == ST_LOAD_WAIT && mem_rvalid && op_reg == o;
  endsequence

  AST_ADDR_FORM: assert property (
    accept && ldst_c && !fault_c |=>
      mem_valid && mem.addr == $past(req.src_val) + {{48{$past(req.imm[15])}}, $past(req.imm)})
    else $error("effective address wrong");

  AST_BYTE_SIGNED: assert property (
    s_load_back(lsa_pkg::OP_LOAD_BYTE_SIGNED) |=> wb_valid && wb.data[63:8] == {56{wb.data[7]}})
    else $error("signed byte not extended");

  AST_BYTE_ZERO: assert property (
    s_load_back(lsa_pkg::OP_LOAD_BYTE_ZERO_EXT) |=> wb_valid && wb.data[63:8] == 56'h0)
    else $error("unsigned byte not zero filled");

  AST_HALF_ZERO: assert property (
    s_load_back(lsa_pkg::OP_LOAD_HALF_ZERO_EXT) |=>
      wb_valid && wb.data == {48'h0, $past(mem_rdata[{boff_reg[2:1], 4'h0} +: 16])})
    else $error("unsigned half wrong");

  AST_WORD_SEXT: assert property (
    state_reg == ST_LOAD_WAIT && mem_rvalid && op_reg inside {lsa_pkg::OP_LOAD_WORD_SIGNED,
      lsa_pkg::OP_LOAD_WORD_LEFT_PART, lsa_pkg::OP_LOAD_WORD_RIGHT_PART}
      |=> wb.data[63:32] == {32{wb.data[31]}})
    else $error("word load not sign extended");

  AST_STORE_BYTE: assert property (
    s_ok_accept(lsa_pkg::OP_STORE_BYTE) |=>
      mem.we && $onehot(mem.be) && mem.wdata[7:0] == $past(req.tgt_val[7:0]))
    else $error("byte store lanes wrong");

  AST_STORE_WORD: assert property (
    s_ok_accept(lsa_pkg::OP_STORE_WORD) |=>
      mem.be inside {8'h0F, 8'hF0} && mem.wdata[31:0] == $past(req.tgt_val[31:0]))
    else $error("word store lanes wrong");

  AST_TRAP_OVF: assert property (
    accept && req.op == lsa_pkg::OP_ADD_IMM_TRAPPING && alu_ovf_c |=>
      exc_valid && exc.overflow && !wb_valid && state_reg == ST_IDLE)
    else $error("overflow did not trap");

  AST_NO_TRAP: assert property (
    accept && req.op == lsa_pkg::OP_ADD_IMM_NONTRAPPING |=> !exc_valid && wb_valid)
    else $error("non-trapping add raised exception");

  AST_LOAD_UPPER: assert property (
    s_ok_accept(lsa_pkg::OP_LOAD_UPPER_IMM) |=> wb_valid && wb.data[15:0] == 16'h0
      && wb.data[31:16] == $past(req.imm) && wb.data[63:32] == {32{wb.data[31]}})
    else $error("load upper result wrong");

  AST_MISALIGN: assert property (
    accept && ldst_c && misal_c |=> exc_valid && exc.addr_err && !mem_valid ##1 req_ready)
    else $error("misaligned access not refused");

  AST_LOAD_FLOW: assert property (
    s_ok_accept(lsa_pkg::OP_LOAD_DWORD) ##1 (mem_valid && mem_gnt) ##2 mem_rvalid
      |=> wb_valid && wb.data == $past(mem_rdata))
    else $error("doubleword load not passed unchanged");

endmodule : lsa_exec

/* lsa_imm_alu.sv */
`timescale 1ns/1ps
module lsa_imm_alu (
  input  wire lsa_pkg::lsa_op_t op,      // Immediate operation
  input  wire logic [63:0]      src_val, // Source register value
  input  wire logic [15:0]      imm,     // Immediate field
  output logic      [63:0]      result,  // Value for the destination
  output logic                  ovf      // Signed 32-bit overflow of the add
);

  logic [63:0] imm_sx;
  logic [63:0] imm_zx;
  logic [32:0] sum33;

  assign imm_sx = {{48{imm[15]}}, imm};
  assign imm_zx = {48'h0, imm};
  // Operands are taken as properly sign-extended words
  assign sum33  = {src_val[31], src_val[31:0]} + {imm_sx[31], imm_sx[31:0]};
  assign ovf    = sum33[32] != sum33[31];

  always_comb begin
    case (op)
      lsa_pkg::OP_ADD_IMM_TRAPPING,
      lsa_pkg::OP_ADD_IMM_NONTRAPPING: result = {{32{sum33[31]}}, sum33[31:0]};
      lsa_pkg::OP_SET_LESS_IMM_SIGNED:
        result = {63'h0, $signed(src_val) < $signed(imm_sx)};
      lsa_pkg::OP_SET_LESS_IMM_UNSIGNED: result = {63'h0, src_val < imm_sx};
      lsa_pkg::OP_AND_IMM: result = src_val & imm_zx;
      lsa_pkg::OP_OR_IMM:  result = src_val | imm_zx;
      lsa_pkg::OP_XOR_IMM: result = src_val ^ imm_zx;
      lsa_pkg::OP_LOAD_UPPER_IMM: result = {{32{imm[15]}}, imm, 16'h0};
      default: result = 64'h0;
    endcase
  end

endmodule : lsa_imm_alu

/* lsa_mem_model.sv */
`timescale 1ns/1ps
module lsa_mem_model #(
  parameter logic [63:0] PAT = 64'h8765_4321_FEDC_BA98  // Doubleword returned for any read
) (
  input  wire logic              clk,        // Core clock
  input  wire logic              reset_n,    // Synchronous reset
  input  wire logic              slow,       // Stall grant and read data
  input  wire logic              mem_valid,  // Request pending
  input  wire lsa_pkg::lsa_mem_t mem,        // Request fields
  output logic                   mem_gnt,    // Request accepted
  output logic                   mem_rvalid, // Read data pulse
  output logic [63:0]            mem_rdata   // Read data
);
  logic [2:0] gcnt_reg;
  logic [2:0] rcnt_reg;

  assign mem_gnt = mem_valid && (gcnt_reg >= (slow ? 3'h3 : 3'h0));
  // Lane n is the byte at offset n; idle bus shows the inverse, never the last value
  assign mem_rdata = mem_rvalid ? PAT : ~PAT;

  always_ff @(posedge clk) begin
    if (!reset_n || !mem_valid || mem_gnt) begin
      gcnt_reg <= 3'h0;
    end else begin
      gcnt_reg <= gcnt_reg + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rcnt_reg   <= 3'h0;
      mem_rvalid <= 1'b0;
    end else begin
      mem_rvalid <= (rcnt_reg == 3'h1);
      if (mem_valid && mem_gnt && !mem.we) begin
        rcnt_reg <= slow ? 3'h4 : 3'h1;
      end else if (rcnt_reg != 3'h0) begin
        rcnt_reg <= rcnt_reg - 3'h1;
      end
    end
  end
endmodule : lsa_mem_model

/* lsa_pkg.sv */
package lsa_pkg;

  localparam int XLEN       = 64;
  localparam int HALF_XLEN  = 32;
  localparam int IMM_W      = 16;
  localparam int REG_ID_W   = 5;
  localparam int LANES      = 8;

  // Byte-enable patterns, lane 0 is the lowest address (little endian)
  localparam logic [7:0] BE_NONE  = 8'h00;
  localparam logic [7:0] BE_BYTE  = 8'h01;
  localparam logic [7:0] BE_HALF  = 8'h03;
  localparam logic [7:0] BE_WORD  = 8'h0F;
  localparam logic [7:0] BE_ALL   = 8'hFF;
  localparam logic [3:0] BE_WLANE = 4'hF;

  localparam logic [63:0] ONES64 = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [31:0] ONES32 = 32'hFFFF_FFFF;

  typedef enum logic [4:0] {
    OP_LOAD_BYTE_SIGNED, OP_LOAD_BYTE_ZERO_EXT, OP_LOAD_HALF_SIGNED,
    OP_LOAD_HALF_ZERO_EXT, OP_LOAD_WORD_SIGNED, OP_LOAD_WORD_LEFT_PART,
    OP_LOAD_WORD_RIGHT_PART, OP_LOAD_WORD_ZERO_EXT, OP_LOAD_DWORD,
    OP_LOAD_DWORD_LEFT_PART, OP_LOAD_DWORD_RIGHT_PART,
    OP_STORE_BYTE, OP_STORE_HALF, OP_STORE_WORD, OP_STORE_WORD_LEFT_PART,
    OP_STORE_WORD_RIGHT_PART, OP_STORE_DWORD, OP_STORE_DWORD_LEFT_PART,
    OP_STORE_DWORD_RIGHT_PART,
    OP_ADD_IMM_TRAPPING, OP_ADD_IMM_NONTRAPPING, OP_SET_LESS_IMM_SIGNED,
    OP_SET_LESS_IMM_UNSIGNED, OP_AND_IMM, OP_OR_IMM, OP_XOR_IMM,
    OP_LOAD_UPPER_IMM
  } lsa_op_t;

  typedef struct packed {
    lsa_op_t             op;
    logic [XLEN-1:0]     src_val;  // Base or source register value
    logic [XLEN-1:0]     tgt_val;  // Target register: store data or merge base
    logic [IMM_W-1:0]    imm;      // Offset or immediate
    logic [REG_ID_W-1:0] tgt_reg;  // Destination register number
  } lsa_req_t;

  typedef struct packed {
    logic [XLEN-1:0]  addr;
    logic             we;
    logic [LANES-1:0] be;
    logic [XLEN-1:0]  wdata;
  } lsa_mem_t;

  typedef struct packed {
    logic [REG_ID_W-1:0] tgt_reg;
    logic [XLEN-1:0]     data;
  } lsa_wb_t;

  typedef struct packed {
    logic addr_err;
    logic overflow;
    logic reserved;
  } lsa_exc_t;

  function automatic logic is_load(lsa_op_t op);
    return op <= OP_LOAD_DWORD_RIGHT_PART;
  endfunction : is_load

  function automatic logic is_store(lsa_op_t op);
    return (op >= OP_STORE_BYTE) && (op <= OP_STORE_DWORD_RIGHT_PART);
  endfunction : is_store

  function automatic logic needs_64(lsa_op_t op);
    return op inside {OP_LOAD_WORD_ZERO_EXT, OP_LOAD_DWORD, OP_LOAD_DWORD_LEFT_PART,
                      OP_LOAD_DWORD_RIGHT_PART, OP_STORE_DWORD,
                      OP_STORE_DWORD_LEFT_PART, OP_STORE_DWORD_RIGHT_PART};
  endfunction : needs_64

endpackage : lsa_pkg

/* tb_load_store_and_immediate_alu.sv */
`timescale 1ns/1ps
module tb_load_store_and_immediate_alu;
  typedef struct {
    lsa_pkg::lsa_op_t op;
    logic [63:0]      s;
    logic [15:0]      i;
    logic [1:0]       k;  // 0 write-back, 1 exception, 2 store
    logic [63:0]      e;
    logic [7:0]       b;
  } lsa_row_t;

  localparam logic [63:0] TG  = 64'h1122_3344_5566_7788;
  localparam logic [63:0] PAT = 64'h8765_4321_FEDC_BA98;

  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              mode64 = 1'b1;
  logic              slow = 1'b0;
  logic              req_valid = 1'b0;
  logic              req_ready;
  lsa_pkg::lsa_req_t req = '0;
  logic              mem_valid;
  lsa_pkg::lsa_mem_t mem;
  logic              mem_gnt;
  logic              mem_rvalid;
  logic [63:0]       mem_rdata;
  logic              wb_valid;
  lsa_pkg::lsa_wb_t  wb;
  logic              exc_valid;
  lsa_pkg::lsa_exc_t exc;
  int                failures = 0;
  int                num_checks = 0;

  lsa_row_t rows [31] = '{
    '{lsa_pkg::OP_LOAD_BYTE_SIGNED, 64'h1008, 16'hFFF9, 2'h0, 64'hFFFFFFFFFFFFFFBA, 8'hFF},
    '{lsa_pkg::OP_LOAD_BYTE_ZERO_EXT, 64'h1000, 16'h0003, 2'h0, 64'hFE, 8'hFF},
    '{lsa_pkg::OP_LOAD_HALF_SIGNED, 64'h1000, 16'h0002, 2'h0, 64'hFFFFFFFFFFFFFEDC, 8'hFF},
    '{lsa_pkg::OP_LOAD_HALF_ZERO_EXT, 64'h1000, 16'h0006, 2'h0, 64'h8765, 8'hFF},
    '{lsa_pkg::OP_LOAD_WORD_SIGNED, 64'h1000, 16'h0004, 2'h0, 64'hFFFFFFFF87654321, 8'hFF},
    '{lsa_pkg::OP_LOAD_WORD_ZERO_EXT, 64'h1000, 16'h0000, 2'h0, 64'hFEDCBA98, 8'hFF},
    '{lsa_pkg::OP_LOAD_DWORD, 64'h1000, 16'h0000, 2'h0, PAT, 8'hFF},
    '{lsa_pkg::OP_LOAD_WORD_LEFT_PART, 64'h1000, 16'h0001, 2'h0,
      64'hFFFFFFFFBA987788, 8'hFF},
    '{lsa_pkg::OP_LOAD_WORD_RIGHT_PART, 64'h1000, 16'h0002, 2'h0,
      64'h5566FEDC, 8'hFF},
    '{lsa_pkg::OP_LOAD_DWORD_LEFT_PART, 64'h1000, 16'h0002, 2'h0,
      64'hDCBA984455667788, 8'hFF},
    '{lsa_pkg::OP_LOAD_DWORD_RIGHT_PART, 64'h1000, 16'h0005, 2'h0,
      64'h1122334455876543, 8'hFF},
    '{lsa_pkg::OP_STORE_BYTE, 64'h1000, 16'h0003, 2'h2, 64'h88000000, 8'h08},
    '{lsa_pkg::OP_STORE_HALF, 64'h1000, 16'h0006, 2'h2, 64'h7788000000000000, 8'hC0},
    '{lsa_pkg::OP_STORE_WORD, 64'h1000, 16'h0004, 2'h2, 64'h5566778800000000, 8'hF0},
    '{lsa_pkg::OP_STORE_WORD_LEFT_PART, 64'h1000, 16'h0001, 2'h2, 64'h5566, 8'h03},
    '{lsa_pkg::OP_STORE_WORD_RIGHT_PART, 64'h1000, 16'h0006, 2'h2,
      64'h7788000000000000, 8'hC0},
    '{lsa_pkg::OP_STORE_DWORD, 64'h1000, 16'h0008, 2'h2, TG, 8'hFF},
    '{lsa_pkg::OP_STORE_DWORD_LEFT_PART, 64'h1000, 16'h0002, 2'h2, 64'h112233, 8'h07},
    '{lsa_pkg::OP_STORE_DWORD_RIGHT_PART, 64'h1000, 16'h0005, 2'h2,
      64'h6677880000000000, 8'hE0},
    '{lsa_pkg::OP_ADD_IMM_TRAPPING, 64'h7FFFFFF0, 16'h0010, 2'h1, 64'h2, 8'h00},
    '{lsa_pkg::OP_ADD_IMM_TRAPPING, 64'h5, 16'hFFFF, 2'h0, 64'h4, 8'h00},
    '{lsa_pkg::OP_ADD_IMM_NONTRAPPING, 64'h7FFFFFF0, 16'h0010, 2'h0,
      64'hFFFFFFFF80000000, 8'h00},
    '{lsa_pkg::OP_SET_LESS_IMM_SIGNED, 64'hFFFFFFFFFFFFFFFE, 16'hFFFF, 2'h0, 64'h1, 8'h00},
    '{lsa_pkg::OP_SET_LESS_IMM_UNSIGNED, 64'h5, 16'hFFFF, 2'h0, 64'h1, 8'h00},
    '{lsa_pkg::OP_AND_IMM, 64'hFFFFFFFFFFFFFFFF, 16'h8421, 2'h0, 64'h8421, 8'h00},
    '{lsa_pkg::OP_OR_IMM, 64'h1234000000000000, 16'hF00F, 2'h0, 64'h123400000000F00F, 8'h00},
    '{lsa_pkg::OP_XOR_IMM, 64'hFFFFFFFFFFFF0F0F, 16'hFFFF, 2'h0, 64'hFFFFFFFFFFFFF0F0, 8'h00},
    '{lsa_pkg::OP_LOAD_UPPER_IMM, 64'h0, 16'h8001, 2'h0, 64'hFFFFFFFF80010000, 8'h00},
    '{lsa_pkg::OP_LOAD_HALF_SIGNED, 64'h1000, 16'h0001, 2'h1, 64'h4, 8'h00},
    '{lsa_pkg::OP_LOAD_WORD_SIGNED, 64'h1000, 16'h0002, 2'h1, 64'h4, 8'h00},
    '{lsa_pkg::OP_LOAD_DWORD, 64'h1000, 16'h0004, 2'h1, 64'h4, 8'h00}
  };

  lsa_exec i_dut (
    .clk(clk), .reset_n(reset_n), .mode64(mode64), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .mem_valid(mem_valid), .mem(mem),
    .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .wb_valid(wb_valid), .wb(wb), .exc_valid(exc_valid), .exc(exc)
  );

  lsa_mem_model #(.PAT(PAT)) i_mem (
    .clk(clk), .reset_n(reset_n), .slow(slow), .mem_valid(mem_valid), .mem(mem),
    .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata)
  );

  always #25 clk = ~clk;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // Entered just after a rising edge; one request, then wait for its outcome
  task automatic run(input lsa_row_t r);
    logic        done;
    logic [63:0] ea;
    logic [63:0] mk;
    ea = r.s + {{48{r.i[15]}}, r.i};
    for (int j = 0; j < 8; j++) mk[j*8+:8] = {8{r.b[j]}};
    req = '{r.op, r.s, TG, r.i, 5'h0A};
    req_valid = 1'b1;
    done = 1'b0;
    for (int n = 0; n < 20 && !done; n++) begin
      @(posedge clk);
      #1;
      if (n == 0) req_valid = 1'b0;
      if (mem_valid && mem_gnt) begin
        chk(mem.addr, ea);
        chk(mem.we, r.k == 2'h2);
        chk(mem.be, r.b);
        if (r.k == 2'h2) chk(mem.wdata & mk, r.e & mk);
        done = (r.k == 2'h2);
      end
      if (wb_valid) begin
        chk(r.k, 2'h0);
        chk(wb.data, r.e);
        chk(wb.tgt_reg, 5'h0A);
        done = 1'b1;
      end
      if (exc_valid) begin
        chk(r.k, 2'h1);
        chk(exc, r.e[2:0]);
        done = 1'b1;
      end
      if (!done && r.b != 8'h00) chk(req_ready, 1'b0);
    end
    chk(done, 1'b1);
    @(posedge clk);
    #1;
  endtask : run

  initial begin
    #100000;
    failures++;
    finish_test();
  end

  initial begin
    repeat (5) @(posedge clk);
    #1;
    chk(req_ready, 1'b1);
    chk({mem_valid, wb_valid, exc_valid}, 3'h0);
    reset_n = 1'b1;
    foreach (rows[x]) run(rows[x]);
    // Immediate ops back to back, ready never drops
    req = '{lsa_pkg::OP_ADD_IMM_NONTRAPPING, 64'h1, TG, 16'h0001, 5'h03};
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    chk(wb_valid, 1'b1);
    chk(wb.data, 64'h2);
    chk(wb.tgt_reg, 5'h03);
    chk(req_ready, 1'b1);
    req.imm = 16'h0002;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    chk(wb_valid, 1'b1);
    chk(wb.data, 64'h3);
    @(posedge clk);
    #1;
    chk(wb_valid, 1'b0);
    mode64 = 1'b0;
    run('{lsa_pkg::OP_LOAD_DWORD, 64'h1000, 16'h0000, 2'h1, 64'h1, 8'h00});
    mode64 = 1'b1;
    slow = 1'b1;
    run(rows[4]);
    // Reset while a load waits for its grant
    req = '{lsa_pkg::OP_LOAD_DWORD, 64'h1000, TG, 16'h0000, 5'h01};
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    reset_n = 1'b0;
    @(posedge clk);
    #1;
    chk({req_ready, mem_valid, wb_valid, exc_valid}, 4'h8);
    chk(wb.data, 64'h0);
    reset_n = 1'b1;
    slow = 1'b0;
    run(rows[20]);
    finish_test();
  end
endmodule : tb_load_store_and_immediate_alu
